// ### core/frm_monitor.sv
// fast current level alarm, phase angle, zero cross and temperature monitor
`include "frm_regs.svh"
`default_nettype none
module frm_monitor #(
  parameter int P_HALF50_CYC = `FRM_HALF50_US * `FRM_CLK_MHZ,
  parameter int P_HALF60_CYC = `FRM_HALF60_US * `FRM_CLK_MHZ,
  parameter int P_ZX_CYC = `FRM_ZX_DLY_US * `FRM_CLK_MHZ,
  parameter int P_TIVL_CYC = `FRM_TIVL_BASE_MS * 1000 * `FRM_CLK_MHZ
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // register access from the serial frame engine
  input wire frm_pkg::frm_req_t i_reg,
  output logic [23:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // waveform samples and energy pulses
  input wire frm_pkg::frm_wave_t i_wave,
  input wire logic i_energy_pulse,
  // pins
  output logic o_energy_pulse_pin,
  output logic o_zero_cross_output,
  // temperature converter
  input wire logic i_sar_cmp,
  output logic o_sar_sel,
  output logic [9:0] o_sar_dac
);
  import frm_pkg::*;
  localparam int TICK_DIV = `FRM_CLK_MHZ / `FRM_FS_MHZ;
  localparam int P_RESP50_CYC = `FRM_RESP50_MS * 1000 * `FRM_CLK_MHZ;
  localparam int P_RESP60_CYC = `FRM_RESP60_MS * 1000 * `FRM_CLK_MHZ;

  // software registers
  logic [15:0] ctrl_ff;
  logic [15:0] mode_ff;
  logic [15:0] tctl_ff;
  logic [7:0] rmsos_ff;
  logic [7:0] tgain_ff;
  logic [7:0] tofs_ff;
  logic [23:0] rdata_ff;
  logic rvalid_ff;
  logic [23:0] nxt_rdata;
  // fast level path
  logic [23:0] lp_ff;
  logic [31:0] acc_ff;
  logic [23:0] win_cnt_ff;
  logic [23:0] fast_ff;
  logic leak_ff;
  logic [23:0] half_len;
  logic [23:0] win_len;
  logic win_end;
  logic [23:0] x24;
  logic [23:0] hp_diff;
  logic [23:0] filtered_current_waveform;
  logic [23:0] mag;
  logic [23:0] nxt_fast;
  // phase and zero cross
  logic [4:0] tick_cnt_ff;
  logic tick_ff;
  logic vsign_ff;
  logic csign_ff;
  logic [15:0] ang_cnt_ff;
  logic [15:0] phase_ff;
  logic [15:0] zx_cnt_ff;
  logic zx_pend_ff;
  logic zx_ff;
  logic volt_zc;
  logic cur_zc;
  // temperature
  frm_tseq_t tseq_ff;
  logic [23:0] ivl_cnt_ff;
  logic [23:0] ivl_len;
  logic ivl_fire;
  logic alt_ff;
  logic sar_start_ff;
  logic sar_sel_ff;
  logic [9:0] tint_ff;
  logic [9:0] text_ff;
  logic tmp_alarm_ff;
  logic pin_ff;
  logic sar_done;
  logic sar_busy;
  logic [9:0] sar_code;

  // level from the sum; a full cycle sum is halved so both windows share one scale
  function automatic logic [23:0] fast_of(input logic [31:0] acc, input logic full);
    logic [31:0] s;
    s = full ? (acc >> 1) : acc;
    return (|s[31:24]) ? 24'hffffff : s[23:0];
  endfunction

  // register writes; read only offsets silently ignore writes
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_ff <= `FRM_RST_CTRL;
      mode_ff <= `FRM_RST_MODE;
      tctl_ff <= `FRM_RST_TCTL;
      rmsos_ff <= 8'h00;
      tgain_ff <= 8'h00;
      tofs_ff <= 8'h00;
    end else if (i_reg.wr) begin
      case (i_reg.addr)
        `FRM_OFS_CTRL: ctrl_ff <= i_reg.wdata[15:0];
        `FRM_OFS_MODE: mode_ff <= i_reg.wdata[15:0];
        `FRM_OFS_TCTL: tctl_ff <= i_reg.wdata[15:0];
        `FRM_OFS_RMSOS: rmsos_ff <= i_reg.wdata[7:0];
        `FRM_OFS_TGAIN: tgain_ff <= i_reg.wdata[7:0];
        `FRM_OFS_TOFS: tofs_ff <= i_reg.wdata[7:0];
        default: ;
      endcase
    end
  end

  // read mux, narrow registers padded with zeros to three bytes
  always_comb begin
    case (i_reg.addr)
      `FRM_OFS_FAST: nxt_rdata = fast_ff;
      `FRM_OFS_PHASE: nxt_rdata = {8'h00, phase_ff};
      `FRM_OFS_TINT: nxt_rdata = {14'h0, tint_ff};
      `FRM_OFS_TEXT: nxt_rdata = {14'h0, text_ff};
      `FRM_OFS_CTRL: nxt_rdata = {8'h00, ctrl_ff};
      `FRM_OFS_RMSOS: nxt_rdata = {16'h0000, rmsos_ff};
      `FRM_OFS_MODE: nxt_rdata = {8'h00, mode_ff};
      `FRM_OFS_TCTL: nxt_rdata = {8'h00, tctl_ff};
      `FRM_OFS_TGAIN: nxt_rdata = {16'h0000, tgain_ff};
      `FRM_OFS_TOFS: nxt_rdata = {16'h0000, tofs_ff};
      default: nxt_rdata = 24'h000000;
    endcase
  end

  // read answer one cycle after the request, held until the next read
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 24'h000000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= i_reg.rd;
      if (i_reg.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // source selection, filter and magnitude
  always_comb begin
    x24 = {{4{i_wave.cur[19]}}, i_wave.cur};
    hp_diff = 24'(x24 - lp_ff);
    filtered_current_waveform = mode_ff[`FRM_MODE_HPF] ? hp_diff : x24;
    mag = filtered_current_waveform[23] ? 24'(-filtered_current_waveform) : filtered_current_waveform;
    half_len = mode_ff[`FRM_MODE_60HZ] ? 24'(P_HALF60_CYC) : 24'(P_HALF50_CYC);
    win_len = ctrl_ff[`FRM_CTRL_FULL] ? {half_len[22:0], 1'b0} : half_len;
    win_end = (win_cnt_ff >= 24'(win_len - 24'h000001));
    nxt_fast = fast_of(acc_ff, ctrl_ff[`FRM_CTRL_FULL]);
  end

  // filter tracks the dc part with a slow leaky average
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lp_ff <= 24'h000000;
    end else if (i_wave.vld) begin
      lp_ff <= 24'(lp_ff + {{8{hp_diff[23]}}, hp_diff[23:8]});
    end
  end

  // window counter and absolute sum; the window runs on time, not on crossings
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      win_cnt_ff <= 24'h000000;
      acc_ff <= 32'h00000000;
    end else if (win_end) begin
      win_cnt_ff <= 24'h000000;
      acc_ff <= i_wave.vld ? {8'h00, mag} : 32'h00000000;
    end else begin
      win_cnt_ff <= 24'(win_cnt_ff + 24'h000001);
      if (i_wave.vld) begin
        acc_ff <= 32'(acc_ff + {8'h00, mag});
      end
    end
  end

  // refresh and compare only at window end, so the alarm lags by at most two windows
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fast_ff <= 24'h000000;
      leak_ff <= 1'b0;
    end else if (win_end) begin
      fast_ff <= nxt_fast;
      leak_ff <= (nxt_fast[`FRM_FAST_CMP_HI:`FRM_FAST_CMP_LO] >= ctrl_ff[`FRM_CTRL_THR_HI:0]);
    end
  end

  // sampling rate tick for the phase count
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_ff <= 5'h00;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == 5'(TICK_DIV - 1));
      tick_cnt_ff <= (tick_cnt_ff == 5'(TICK_DIV - 1)) ? 5'h00 : 5'(tick_cnt_ff + 5'h01);
    end
  end

  // positive crossings: sign goes from negative to non negative
  assign volt_zc = i_wave.vld && vsign_ff && !i_wave.volt[19];
  assign cur_zc = i_wave.vld && csign_ff && !i_wave.cur[19];

  // phase count restarts at voltage crossing, saturates rather than wraps
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vsign_ff <= 1'b0;
      csign_ff <= 1'b0;
      ang_cnt_ff <= 16'h0000;
      phase_ff <= 16'h0000;
    end else begin
      if (i_wave.vld) begin
        vsign_ff <= i_wave.volt[19];
        csign_ff <= i_wave.cur[19];
      end
      if (volt_zc) begin
        ang_cnt_ff <= 16'h0000;
      end else if (tick_ff && ang_cnt_ff != 16'hffff) begin
        ang_cnt_ff <= 16'(ang_cnt_ff + 16'h0001);
      end
      if (cur_zc) begin
        phase_ff <= ang_cnt_ff;
      end
    end
  end

  // zero cross pin follows the voltage sign after a fixed delay
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zx_cnt_ff <= 16'h0000;
      zx_pend_ff <= 1'b0;
      zx_ff <= 1'b0;
    end else begin
      if (i_wave.vld && (i_wave.volt[19] != vsign_ff)) begin
        zx_cnt_ff <= 16'(P_ZX_CYC);
        zx_pend_ff <= i_wave.volt[19];
      end else if (zx_cnt_ff != 16'h0000) begin
        zx_cnt_ff <= 16'(zx_cnt_ff - 16'h0001);
      end
      if (zx_cnt_ff == 16'h0001) begin
        zx_ff <= zx_pend_ff;
      end
    end
  end

  // measurement interval doubles per step of the interval field
  always_comb begin
    ivl_len = 24'(P_TIVL_CYC) << tctl_ff[`FRM_TCTL_IVL_HI:`FRM_TCTL_IVL_LO];
    ivl_fire = !tctl_ff[`FRM_TCTL_OFF] && (ivl_cnt_ff >= 24'(ivl_len - 24'h000001));
  end

  // interval timer, held at zero while measurement is off
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ivl_cnt_ff <= 24'h000000;
    end else if (tctl_ff[`FRM_TCTL_OFF] || ivl_fire) begin
      ivl_cnt_ff <= 24'h000000;
    end else begin
      ivl_cnt_ff <= 24'(ivl_cnt_ff + 24'h000001);
    end
  end

  // conversion sequencer; automatic mode alternates internal and external
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tseq_ff <= TS_IDLE;
      alt_ff <= 1'b0;
      sar_start_ff <= 1'b0;
      sar_sel_ff <= 1'b0;
      tint_ff <= 10'h000;
      text_ff <= 10'h000;
    end else begin
      sar_start_ff <= 1'b0;
      case (tseq_ff)
        TS_IDLE: begin
          if (ivl_fire && !sar_busy) begin
            sar_start_ff <= 1'b1;
            sar_sel_ff <= (tctl_ff[`FRM_TCTL_SRC_HI:`FRM_TCTL_SRC_LO] == 2'h3) ||
                          (!tctl_ff[`FRM_TCTL_SRC_HI] && alt_ff);
            tseq_ff <= TS_CONV;
          end
        end
        TS_CONV: begin
          if (sar_done) begin
            if (sar_sel_ff) begin
              text_ff <= sar_code;
            end else begin
              tint_ff <= sar_code;
            end
            alt_ff <= !alt_ff;
            tseq_ff <= TS_IDLE;
          end
        end
        default: tseq_ff <= TS_IDLE;
      endcase
    end
  end

  // temperature alarm and pulse pin routing
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tmp_alarm_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      tmp_alarm_ff <= !tctl_ff[`FRM_TCTL_OFF] && (text_ff >= tctl_ff[`FRM_TCTL_THR_HI:0]);
      if (mode_ff[`FRM_MODE_PIN_ALARM]) begin
        pin_ff <= tctl_ff[`FRM_TCTL_LEAK] ? leak_ff : tmp_alarm_ff;
      end else begin
        pin_ff <= i_energy_pulse && mode_ff[`FRM_MODE_PULSE_EN];
      end
    end
  end

  // shared converter
  frm_sar u_sar (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_start(sar_start_ff),
    .i_cmp(i_sar_cmp),
    .o_dac(o_sar_dac),
    .o_code(sar_code),
    .o_busy(sar_busy),
    .o_done(sar_done)
  );

  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
  assign o_energy_pulse_pin = pin_ff;
  assign o_zero_cross_output = zx_ff;
  assign o_sar_sel = sar_sel_ff;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence refresh_s;
    win_end ##1 1'b1;
  endsequence
  leak_refresh_a: assert property (refresh_s |-> leak_ff == (fast_ff[23:9] >= $past(ctrl_ff[14:0])))
    else $error("leakage alarm disagrees with refreshed level");
  leak_hold_a: assert property (!win_end |=> $stable(leak_ff) && $stable(fast_ff))
    else $error("leakage alarm moved between refreshes");
  win_bound_a: assert property (ctrl_ff[15] && !mode_ff[9] |-> win_cnt_ff < 24'(P_RESP50_CYC))
    else $error("full cycle window too long at 50 Hz");
  win_bound60_a: assert property (ctrl_ff[15] && mode_ff[9] |-> win_cnt_ff < 24'(P_RESP60_CYC))
    else $error("full cycle window too long at 60 Hz");
  phase_load_a: assert property (cur_zc |=> phase_ff == $past(ang_cnt_ff))
    else $error("phase angle not loaded at current crossing");
  tick_gap_a: assert property (tick_ff |=> !tick_ff [*8])
    else $error("sampling tick too fast");
  zx_delay_a: assert property (i_wave.vld && (i_wave.volt[19] != vsign_ff) |=> $stable(zx_ff) [*8])
    else $error("zero cross pin changed without delay");
  pin_leak_a: assert property (mode_ff[12] && tctl_ff[14] |=> o_energy_pulse_pin == $past(leak_ff))
    else $error("leakage alarm not routed to pulse pin");
  pin_pulse_a: assert property (!mode_ff[12] && !mode_ff[11] |=> !o_energy_pulse_pin)
    else $error("pulse pin active while pulses disabled");
  temp_alarm_a: assert property (!tctl_ff[15] && (text_ff >= tctl_ff[9:0]) |=> tmp_alarm_ff)
    else $error("temperature alarm missing");
  temp_off_a: assert property (tctl_ff[15] |=> !sar_start_ff && !tmp_alarm_ff)
    else $error("temperature activity while switched off");
  rd_pad_a: assert property (i_reg.rd && i_reg.addr == 8'h0e |=> o_reg_rvalid && o_reg_rdata[23:10] == 14'h0000)
    else $error("narrow register read with nonzero upper bits");
endmodule
`default_nettype wire

// ### inc/frm_regs.svh
// register offsets, field positions, reset values and timing figures of the fast level monitor
`ifndef FRM_REGS_SVH
`define FRM_REGS_SVH
// register offsets
`define FRM_OFS_FAST 8'h00
`define FRM_OFS_PHASE 8'h0c
`define FRM_OFS_TINT 8'h0e
`define FRM_OFS_TEXT 8'h0f
`define FRM_OFS_CTRL 8'h10
`define FRM_OFS_RMSOS 8'h13
`define FRM_OFS_MODE 8'h18
`define FRM_OFS_TCTL 8'h1b
`define FRM_OFS_TGAIN 8'h1c
`define FRM_OFS_TOFS 8'h1d
// reset values
`define FRM_RST_CTRL 16'hffff
`define FRM_RST_MODE 16'h0000
`define FRM_RST_TCTL 16'h07ff
// fast_level_control fields
`define FRM_CTRL_FULL 15
`define FRM_CTRL_THR_HI 14
`define FRM_FAST_CMP_HI 23
`define FRM_FAST_CMP_LO 9
// user_mode_select fields
`define FRM_MODE_HPF 0
`define FRM_MODE_60HZ 9
`define FRM_MODE_PULSE_EN 11
`define FRM_MODE_PIN_ALARM 12
// temperature_control fields
`define FRM_TCTL_OFF 15
`define FRM_TCTL_LEAK 14
`define FRM_TCTL_SRC_HI 13
`define FRM_TCTL_SRC_LO 12
`define FRM_TCTL_IVL_HI 11
`define FRM_TCTL_IVL_LO 10
`define FRM_TCTL_THR_HI 9
// timing figures
`define FRM_CLK_MHZ 20
`define FRM_FS_MHZ 1
`define FRM_HALF50_US 10000
`define FRM_HALF60_US 8333
`define FRM_RESP50_MS 40
`define FRM_RESP60_MS 33
`define FRM_ZX_DLY_US 570
`define FRM_TIVL_BASE_MS 50
`define FRM_SAR_CYC 11
`endif

// ### inc/frm_pkg.sv
// types shared by the fast level monitor files
`default_nettype none
package frm_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [23:0] wdata;
  } frm_req_t;
  typedef struct packed {
    logic vld;
    logic [19:0] cur;
    logic [19:0] volt;
  } frm_wave_t;
  typedef enum logic {TS_IDLE, TS_CONV} frm_tseq_t;
  typedef enum logic {SAR_IDLE, SAR_CONV} frm_sar_t;
endpackage
`default_nettype wire

// ### core/frm_sar.sv
// ten bit successive approximation sequencer for the temperature inputs
`include "frm_regs.svh"
`default_nettype none
module frm_sar (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // control
  input wire logic i_start,
  input wire logic i_cmp,
  // results
  output logic [9:0] o_dac,
  output logic [9:0] o_code,
  output logic o_busy,
  output logic o_done
);
  import frm_pkg::*;
  frm_sar_t state_ff;
  logic [3:0] idx_ff;
  logic [9:0] dac_ff;
  logic [9:0] code_ff;
  logic done_ff;
  logic [9:0] nxt_kept;

  // comparator high means input at or above trial, so the trial bit stays
  always_comb begin
    nxt_kept = i_cmp ? dac_ff : (dac_ff & ~(10'h001 << idx_ff));
  end

  // one bit per clock, msb first; comparator assumed settled within a cycle
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= SAR_IDLE;
      idx_ff <= 4'h0;
      dac_ff <= 10'h000;
      code_ff <= 10'h000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        SAR_IDLE: begin
          if (i_start) begin
            state_ff <= SAR_CONV;
            idx_ff <= 4'h9;
            dac_ff <= 10'h200;
          end
        end
        SAR_CONV: begin
          if (idx_ff == 4'h0) begin
            code_ff <= nxt_kept;
            done_ff <= 1'b1;
            dac_ff <= nxt_kept;
            state_ff <= SAR_IDLE;
          end else begin
            idx_ff <= 4'(idx_ff - 4'h1);
            dac_ff <= nxt_kept | (10'h001 << 4'(idx_ff - 4'h1));
          end
        end
        default: state_ff <= SAR_IDLE;
      endcase
    end
  end

  assign o_dac = dac_ff;
  assign o_code = code_ff;
  assign o_busy = (state_ff == SAR_CONV);
  assign o_done = done_ff;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  conv_time_a: assert property ((i_start && !o_busy) |-> ##(`FRM_SAR_CYC) o_done)
    else $error("sar conversion did not finish on time");
endmodule
`default_nettype wire

// ### tb/frm_afe_model.sv
// analog front end model: comparator of the ten bit temperature converter
`default_nettype none
module frm_afe_model (
  // converter side
  input wire logic i_sel,
  input wire logic [9:0] i_dac,
  // sensor levels set by the bench
  input wire logic [9:0] i_int_lvl,
  input wire logic [9:0] i_ext_lvl,
  // comparator result
  output logic o_cmp
);
  timeunit 1ns;
  timeprecision 1ns;
  // settles at once on the trial code, so slow sequencers are not hidden
  assign o_cmp = ((i_sel ? i_ext_lvl : i_int_lvl) >= i_dac);
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench of the fast level, phase, zero cross and temperature monitor
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import frm_pkg::*;
  typedef struct {string nm; logic [23:0] exp; int tol;} frm_note_t;
  localparam int HALF5 = 200;
  localparam int HALF6 = 166;
  localparam int TIVL = 64;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  frm_req_t i_reg = '0;
  frm_wave_t i_wave = '0;
  logic i_energy_pulse = 1'b0;
  logic [23:0] o_reg_rdata;
  logic o_reg_rvalid, o_energy_pulse_pin, o_zero_cross_output, o_sar_sel, sar_cmp;
  logic [9:0] o_sar_dac;
  logic [9:0] int_lvl = 10'h155;
  logic [9:0] ext_lvl = 10'h0aa;
  logic [19:0] amp = 20'h00800;
  logic [23:0] lvl;
  logic [31:0] rst_tab [11] = '{32'h00000000, 32'h0c000000, 32'h0e000000, 32'h0f000000, 32'h1000ffff,
    32'h13000000, 32'h18000000, 32'h1b0007ff, 32'h1c000000, 32'h1d000000, 32'h05000000};
  logic [7:0] rw_ofs [6] = '{8'h10, 8'h13, 8'h18, 8'h1b, 8'h1c, 8'h1d};
  logic [23:0] rw_msk [6] = '{24'hffff, 24'hff, 24'hffff, 24'hffff, 24'hff, 24'hff};
  frm_note_t notes [$];
  integer seed = 32'ha5aafeb9;
  logic [23:0] rnd;
  int fails = 0, n_checks = 0, cyc = 0, pos = 0, win, rfr;

  frm_monitor #(.P_HALF50_CYC(HALF5), .P_HALF60_CYC(HALF6), .P_ZX_CYC(20), .P_TIVL_CYC(TIVL)) dut (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_wave(i_wave), .i_energy_pulse(i_energy_pulse),
    .o_energy_pulse_pin(o_energy_pulse_pin), .o_zero_cross_output(o_zero_cross_output),
    .i_sar_cmp(sar_cmp), .o_sar_sel(o_sar_sel), .o_sar_dac(o_sar_dac));
  frm_afe_model afe (.i_sel(o_sar_sel), .i_dac(o_sar_dac), .i_int_lvl(int_lvl), .i_ext_lvl(ext_lvl),
    .o_cmp(sar_cmp));

  always #25 i_clk_sys = ~i_clk_sys;

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test;
    chk("pending reads", 24'h0, 24'(notes.size()));
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge i_clk_sys);
    i_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk_sys);
    i_reg <= '0;
  endtask

  // expected word is noted before the strobe; the read monitor compares it
  task automatic rd(input string nm, input logic [7:0] a, input logic [23:0] e, input int tol = 0);
    notes.push_back('{nm, e, tol});
    @(posedge i_clk_sys);
    i_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h0};
    @(posedge i_clk_sys);
    i_reg <= '0;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // read monitor: oldest note against each returned word, tolerance for counted angles
  always @(posedge i_clk_sys) begin
    frm_note_t n;
    if (o_reg_rvalid === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      if (n.tol > 0 && o_reg_rdata + n.tol >= n.exp && o_reg_rdata <= n.exp + n.tol) n.exp = o_reg_rdata;
      chk(n.nm, n.exp, o_reg_rdata);
    end
  end

  // square mains: voltage positive from pos 0, current 100 cycles later, constant magnitude
  always @(posedge i_clk_sys) begin
    pos <= (pos == 399) ? 0 : pos + 1;
    i_wave.vld <= i_arst_n;
    i_wave.volt <= (pos < 200) ? 20'h04000 : 20'hfc000;
    i_wave.cur <= ((pos + 300) % 400 < 200) ? amp : -amp;
    if (cyc > 1000 && pos % 100 == 10)
      chk("zero cross", 24'((pos >= 200) ^ (pos % 200 < 100)), 24'(o_zero_cross_output));
  end

  // hang guard, well above the roughly 13000 cycles the run needs
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    cycles(4);
    i_arst_n <= 1'b1;
    foreach (rst_tab[i]) rd("reset value", rst_tab[i][31:24], rst_tab[i][23:0]);
    foreach (rst_tab[i]) if (i < 4 || i == 10) wr(rst_tab[i][31:24], 24'($random(seed)));
    foreach (rst_tab[i]) if (i < 4 || i == 10) rd("read only", rst_tab[i][31:24], 24'h0);
    foreach (rw_ofs[i]) begin
      rnd = 24'($random(seed));
      wr(rw_ofs[i], rnd);
      rd("read back", rw_ofs[i], rnd & rw_msk[i]);
    end
    // leakage alarm routed to the pin, both windows and both mains rates
    wr(8'h1b, 24'h0047ff);
    for (int m = 0; m < 4; m++) begin
      win = m[1] ? HALF6 : HALF5;
      rfr = m[0] ? 2 * win : win;
      lvl = 24'(win) * 24'h1000;
      wr(8'h18, {10'h0, 1'b0, 1'b1, 2'b00, m[1], 9'h0});
      wr(8'h10, {8'h0, m[0], lvl[23:9]});
      amp <= 20'h00800;
      cycles(6 * win);
      chk("alarm below", 24'h0, 24'(o_energy_pulse_pin));
      amp <= 20'h01000;
      // one cycle to drive the wave, one for the pin register, one for the edge read
      cycles(2 * rfr + 4);
      chk("alarm at threshold", 24'h1, 24'(o_energy_pulse_pin));
      rd("fast level", 8'h00, lvl);
      wr(8'h10, {8'h0, m[0], lvl[23:9] + 15'h1});
      cycles(2 * rfr + 2);
      chk("alarm released", 24'h0, 24'(o_energy_pulse_pin));
    end
    rd("phase angle", 8'h0c, 24'd5, 1);
    // energy pulse path gated by its enable
    for (int m = 0; m < 4; m++) begin
      wr(8'h18, {12'h0, m[1], 11'h0});
      i_energy_pulse <= m[0];
      cycles(3);
      chk("energy pulse", 24'(m[0] & m[1]), 24'(o_energy_pulse_pin));
    end
    // external only conversions at every interval code
    wr(8'h18, 24'h001000);
    for (int v = 0; v < 4; v++) begin
      ext_lvl <= 10'($random(seed)) & 10'h1fe;
      wr(8'h1b, {8'h0, 4'b0011, v[1:0], 10'h3ff});
      cycles((TIVL << v) * 2 + 30);
      rd("external temperature", 8'h0f, {14'h0, ext_lvl});
    end
    for (int t = 0; t < 3; t++) begin
      wr(8'h1b, {8'h0, t[1], 3'b011, 2'b00, ext_lvl + 10'(t[0])});
      cycles(200);
      chk("temperature alarm", 24'(t == 0), 24'(o_energy_pulse_pin));
    end
    // measurement off: results freeze; then internal only and automatic conversions
    ext_lvl <= ext_lvl + 10'h1;
    cycles(400);
    rd("frozen external", 8'h0f, {14'h0, ext_lvl - 10'h1});
    int_lvl <= 10'h2e1;
    wr(8'h1b, 24'h0023ff);
    cycles(400);
    rd("internal only", 8'h0e, 24'h0002e1);
    rd("external kept", 8'h0f, {14'h0, ext_lvl - 10'h1});
    int_lvl <= 10'h0c7;
    wr(8'h1b, 24'h0013ff);
    cycles(700);
    rd("auto internal", 8'h0e, 24'h0000c7);
    rd("auto external", 8'h0f, {14'h0, ext_lvl});
    cycles(4);
    end_of_test();
  end
endmodule
`default_nettype wire
